/* mpb_port.sv */
// Parallel host bus port: pin decode, address latch, transfers and interrupt pin.
// Functional notes
// [R1] Non-multiplexed: three address pins select the location, lowest pin is the LSB.
// [R2] Multiplexed: system ties bit0 low, leaves bit1 open, bit2 becomes latch strobe.
// [R3] Multiplexed: low address latched from shared low data lines, then lines carry data.
// [R4] Upper five data lines carry data only, never address.
// [R5] 68XX style: data moves only while the low-active data strobe is asserted.
// [R6] 68XX style: direction high means read, low means write.
// [R7] 80XX style: read strobe low makes the device drive the addressed contents.
// [R8] 80XX style: selected with write strobe low, the device accepts bus data.
// [R9] Reads and writes are honoured only while chip select is asserted.
// [R10] Reset pin low puts the whole device into hardware reset; the pin synchroniser is reset only by rst.
// [R11] Interrupt pin goes low for enabled conditions, stays high for masked ones.
module mpb_port #(
    parameter int INT_W = 8
) (
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst,
    // Bus mode straps
    input  wire logic                          busMuxed,
    input  wire logic                          busMotorola,
    // Host address and control pins
    input  wire logic                          addrBit0OrMuxSelectLow,
    input  wire logic                          addressBitOne,
    input  wire logic                          addrBit2OrLatchStrobe,
    input  wire logic                          readOrDataStrobeLow,
    input  wire logic                          writeOrDirection,
    input  wire logic                          chipSelectLow,
    input  wire logic                          hwResetLow,
    // Host data pins
    input  wire logic [mpb_pkg::LOW_W-1:0]     sharedLowAddrDataIn,
    output logic      [mpb_pkg::LOW_W-1:0]     sharedLowAddrDataOut,
    output logic      [mpb_pkg::LOW_W-1:0]     sharedLowAddrDataOe,
    input  wire logic [mpb_pkg::UPPER_W-1:0]   upperDataIn,
    output logic      [mpb_pkg::UPPER_W-1:0]   upperDataOut,
    output logic      [mpb_pkg::UPPER_W-1:0]   upperDataOe,
    // Host interrupt pin
    output logic                               interruptRequestLow,
    // Device register access
    output logic      [mpb_pkg::ADDR_W-1:0]    regAddr,
    output logic      [mpb_pkg::DATA_W-1:0]    regWrData,
    output logic                               regWrite,
    output logic                               regRead,
    input  wire logic [mpb_pkg::DATA_W-1:0]    regRdData,
    // Device interrupt sources and reset
    input  wire logic [INT_W-1:0]              intStatus,
    input  wire logic [INT_W-1:0]              intEnable,
    output logic                               engineReset
);
    mpb_pins_if pins ();

    mpb_pkg::mpb_state_t             state;
    logic                            devReset;
    logic                            selected;
    logic                            rdReq;
    logic                            wrReq;
    logic [mpb_pkg::ADDR_W-1:0]      latchedLow;
    logic [mpb_pkg::ADDR_W-1:0]      directAddr;
    logic [mpb_pkg::ADDR_W-1:0]      curAddr;
    logic [mpb_pkg::DATA_W-1:0]      dataOut;
    logic                            dataOe;
    logic [mpb_pkg::DATA_W-1:0]      wrCapture;
    logic                            irqLow;

    // Read request decode for either strobe style.
    function automatic logic readStrobe(input logic motorola, input logic strobeLow,
                                        input logic wrDir);
        if (motorola)
            readStrobe = !strobeLow && wrDir;  // [R5] [R6]
        else
            readStrobe = !strobeLow;           // [R7]
    endfunction

    // Write request decode for either strobe style.
    function automatic logic writeStrobe(input logic motorola, input logic strobeLow,
                                         input logic wrDir);
        if (motorola)
            writeStrobe = !strobeLow && !wrDir; // [R5] [R6]
        else
            writeStrobe = !wrDir;               // [R8]
    endfunction

    mpb_sync u_sync (
        .clk     (clk),
        .rst     (rst),
        .rawPins ({hwResetLow, chipSelectLow, readOrDataStrobeLow, writeOrDirection,
                   addrBit2OrLatchStrobe, addressBitOne, addrBit0OrMuxSelectLow,
                   upperDataIn, sharedLowAddrDataIn}),
        .pins    (pins.producer)
    );

    // The reset pin holds everything but the pin synchroniser, the engine included, in reset.
    assign devReset = rst || !pins.hwResetLow; // [R10]

    always_ff @(posedge clk)
    begin
        if (rst)
            engineReset <= 1'b1;
        else
            engineReset <= !pins.hwResetLow; // [R10]
    end

    assign selected = !pins.chipSelectLow; // [R9]
    assign rdReq = readStrobe(busMotorola, pins.readOrDataStrobeLow, pins.writeOrDirection);
    assign wrReq = writeStrobe(busMotorola, pins.readOrDataStrobeLow, pins.writeOrDirection);

    // Direct address, lowest pin as the least significant bit.
    assign directAddr = {pins.addrBit2OrLatchStrobe, pins.addressBitOne,
                         pins.addrBit0OrMuxSelectLow}; // [R1]

    // Only the low data lines feed the latch; the upper lines never do.
    always_ff @(posedge clk)
    begin
        if (devReset)
            latchedLow <= mpb_pkg::ADDR_RESET;
        else if (busMuxed && pins.addrBit2OrLatchStrobe)
            latchedLow <= pins.dataLines[mpb_pkg::LOW_W-1:0]; // [R3] [R4]
    end

    assign curAddr = busMuxed ? latchedLow : directAddr; // [R2] [R3]

    // Access sequencer.
    always_ff @(posedge clk)
    begin
        if (devReset)
            state <= mpb_pkg::ST_IDLE;
        else
        begin
            unique case (state)
                mpb_pkg::ST_IDLE:
                begin
                    if (selected && rdReq)
                        state <= mpb_pkg::ST_RD_FETCH; // [R9]
                    else if (selected && wrReq)
                        state <= mpb_pkg::ST_WRITE;    // [R9]
                end
                mpb_pkg::ST_RD_FETCH:
                    state <= mpb_pkg::ST_RD_DRIVE;
                mpb_pkg::ST_RD_DRIVE:
                begin
                    if (!(selected && rdReq))
                        state <= mpb_pkg::ST_IDLE;     // [R5] [R7]
                end
                mpb_pkg::ST_WRITE:
                begin
                    if (!(selected && wrReq))
                        state <= mpb_pkg::ST_IDLE;     // [R8]
                end
                default:
                    state <= mpb_pkg::ST_IDLE;
            endcase
        end
    end

    // Address to the device, taken when an access starts.
    always_ff @(posedge clk)
    begin
        if (devReset)
            regAddr <= mpb_pkg::ADDR_RESET;
        else if (state == mpb_pkg::ST_IDLE && selected && (rdReq || wrReq))
            regAddr <= curAddr; // [R1] [R3]
    end

    // Read request pulse, one cycle at the start of a read.
    always_ff @(posedge clk)
    begin
        if (devReset)
            regRead <= 1'b0;
        else
            regRead <= state == mpb_pkg::ST_IDLE && selected && rdReq; // [R7] [R9]
    end

    // Write data follows the bus while the strobe is held.
    always_ff @(posedge clk)
    begin
        if (devReset)
            wrCapture <= mpb_pkg::DATA_RESET;
        else if (selected && wrReq)
            wrCapture <= pins.dataLines; // [R8]
    end

    // The write is committed when the strobe or the select is released.
    always_ff @(posedge clk)
    begin
        if (devReset)
        begin
            regWrite  <= 1'b0;
            regWrData <= mpb_pkg::DATA_RESET;
        end
        else
        begin
            regWrite <= state == mpb_pkg::ST_WRITE && !(selected && wrReq); // [R8] [R5]
            if (state == mpb_pkg::ST_WRITE && !(selected && wrReq))
                regWrData <= wrCapture;
        end
    end

    // Read data is driven only while the read is selected and strobed.
    always_ff @(posedge clk)
    begin
        if (devReset)
        begin
            dataOut <= mpb_pkg::DATA_RESET;
            dataOe  <= 1'b0;
        end
        else
        begin
            if (state == mpb_pkg::ST_RD_FETCH)
                dataOut <= regRdData; // [R7]
            dataOe <= selected && rdReq &&
                      (state == mpb_pkg::ST_RD_FETCH || state == mpb_pkg::ST_RD_DRIVE); // [R5]
        end
    end

    assign sharedLowAddrDataOut = dataOut[mpb_pkg::LOW_W-1:0];
    assign upperDataOut         = dataOut[mpb_pkg::DATA_W-1:mpb_pkg::LOW_W];
    assign sharedLowAddrDataOe  = {mpb_pkg::LOW_W{dataOe}};
    assign upperDataOe          = {mpb_pkg::UPPER_W{dataOe}};

    mpb_irq #(
        .WIDTH (INT_W)
    ) u_irq (
        .clk                 (clk),
        .rst                 (devReset),
        .intStatus           (intStatus),
        .intEnable           (intEnable),
        .interruptRequestLow (irqLow)
    );

    assign interruptRequestLow = irqLow;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (devReset);

    sequence readStart;
        state == mpb_pkg::ST_IDLE && selected && rdReq;
    endsequence

    sequence writeHeld;
        state == mpb_pkg::ST_WRITE && selected && wrReq;
    endsequence

    sequence writeReleased;
        state == mpb_pkg::ST_WRITE && !(selected && wrReq);
    endsequence

    a_direct_addr: assert property ( // [R1]
        (state == mpb_pkg::ST_IDLE && selected && rdReq && !busMuxed)
            |=> regRead && regAddr == $past(directAddr))
        else $error("direct address not decoded LSB first");

    a_mux_latch: assert property ( // [R3]
        (busMuxed && pins.addrBit2OrLatchStrobe)
            |=> latchedLow == $past(pins.dataLines[mpb_pkg::LOW_W-1:0]))
        else $error("multiplexed address not latched from low lines");

    a_read_drive: assert property ( // [R7]
        readStart ##1 (selected && rdReq)[*2] |=> dataOe && dataOut == $past(regRdData, 2))
        else $error("read data not driven after read strobe");

    a_oe_strobe: assert property ( // [R5]
        dataOe |-> $past(selected && rdReq))
        else $error("data driven without an active read strobe");

    a_dir_decode: assert property ( // [R6]
        (state == mpb_pkg::ST_IDLE && busMotorola && selected &&
         !pins.readOrDataStrobeLow && !pins.writeOrDirection)
            |=> state == mpb_pkg::ST_WRITE && !regRead)
        else $error("direction low did not start a write");

    a_write_commit: assert property ( // [R8]
        writeHeld ##1 writeReleased |=> regWrite && regWrData == $past(wrCapture))
        else $error("write not committed on strobe release");

    a_cs_ignore: assert property ( // [R9]
        (state == mpb_pkg::ST_IDLE && !selected) |=> !regRead && state == mpb_pkg::ST_IDLE)
        else $error("access taken without chip select");

    a_irq_level: assert property ( // [R11]
        (|(intStatus & intEnable)) |=> !interruptRequestLow)
        else $error("enabled interrupt did not assert the pin");

    a_irq_mask: assert property ( // [R11]
        !(|(intStatus & intEnable)) |=> interruptRequestLow)
        else $error("masked condition asserted the interrupt pin");

    a_hw_reset: assert property ( // [R10]
        @(posedge clk) disable iff (rst) !pins.hwResetLow |=> engineReset && !regWrite)
        else $error("reset pin did not reset the device");

    a_read_pulse: assert property ( // [R7]
        regRead |-> state == mpb_pkg::ST_RD_FETCH ##1 !regRead)
        else $error("read request pulse longer than one cycle");

    a_wr_capture: assert property ( // [R4] [R8]
        (selected && wrReq) |=> wrCapture == $past(pins.dataLines))
        else $error("write data not taken from all eight data lines");

    a_oe_release: assert property ( // [R5] [R9]
        (dataOe && !(selected && rdReq)) |=> !dataOe)
        else $error("data still driven after strobe or select released");
endmodule // mpb_port

/* mpb_pkg.sv */
// Shared constants and types for the parallel host bus port.
package mpb_pkg;
    localparam int ADDR_W   = 3;
    localparam int DATA_W   = 8;
    localparam int LOW_W    = 3;
    localparam int UPPER_W  = DATA_W - LOW_W;
    localparam int SYNC_W   = 15;

    // Pin bundle order: {hwReset, cs, rdDs, wrDir, latch/addr2, addr1, addr0, data[7:0]}.
    localparam logic [SYNC_W-1:0] SYNC_IDLE      = 15'h78ff;
    localparam logic [ADDR_W-1:0] ADDR_RESET     = 3'h0;
    localparam logic [DATA_W-1:0] DATA_RESET     = 8'h00;
    localparam logic              IRQ_LOW_RESET  = 1'b1;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RD_FETCH,
        ST_RD_DRIVE,
        ST_WRITE
    } mpb_state_t;
endpackage : mpb_pkg

/* mpb_pins_if.sv */
// Synchronised host pin levels passed from the synchroniser to the port logic.
interface mpb_pins_if;
    logic                        hwResetLow;
    logic                        chipSelectLow;
    logic                        readOrDataStrobeLow;
    logic                        writeOrDirection;
    logic                        addrBit0OrMuxSelectLow;
    logic                        addressBitOne;
    logic                        addrBit2OrLatchStrobe;
    logic [mpb_pkg::DATA_W-1:0]  dataLines;

    modport producer (
        output hwResetLow, chipSelectLow, readOrDataStrobeLow, writeOrDirection,
        output addrBit0OrMuxSelectLow, addressBitOne, addrBit2OrLatchStrobe, dataLines
    );
    modport consumer (
        input hwResetLow, chipSelectLow, readOrDataStrobeLow, writeOrDirection,
        input addrBit0OrMuxSelectLow, addressBitOne, addrBit2OrLatchStrobe, dataLines
    );
endinterface : mpb_pins_if

/* mpb_sync.sv */
// Three-stage pin synchroniser that accepts a level once the last two stages agree.
module mpb_sync (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst,
    // Raw pins
    input  wire logic [mpb_pkg::SYNC_W-1:0]  rawPins,
    // Synchronised levels
    mpb_pins_if.producer                     pins
);
    logic [mpb_pkg::SYNC_W-1:0] stage1;
    logic [mpb_pkg::SYNC_W-1:0] stage2;
    logic [mpb_pkg::SYNC_W-1:0] stage3;
    logic [mpb_pkg::SYNC_W-1:0] stable;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            stage1 <= mpb_pkg::SYNC_IDLE;
            stage2 <= mpb_pkg::SYNC_IDLE;
            stage3 <= mpb_pkg::SYNC_IDLE;
        end
        else
        begin
            stage1 <= rawPins;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // Each bit moves only when the second and third stages agree.
    always_ff @(posedge clk)
    begin
        if (rst)
            stable <= mpb_pkg::SYNC_IDLE;
        else
            stable <= (stage2 & stage3) | (stable & (stage2 ^ stage3));
    end

    assign pins.hwResetLow             = stable[14];
    assign pins.chipSelectLow          = stable[13];
    assign pins.readOrDataStrobeLow    = stable[12];
    assign pins.writeOrDirection       = stable[11];
    assign pins.addrBit2OrLatchStrobe  = stable[10];
    assign pins.addressBitOne          = stable[9];
    assign pins.addrBit0OrMuxSelectLow = stable[8];
    assign pins.dataLines              = stable[7:0];
endmodule // mpb_sync

/* mpb_irq.sv */
// Active-low interrupt output gated by the enable mask.
module mpb_irq #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Conditions and mask
    input  wire logic [WIDTH-1:0] intStatus,
    input  wire logic [WIDTH-1:0] intEnable,
    // Pin level
    output logic                  interruptRequestLow
);
    always_ff @(posedge clk)
    begin
        if (rst)
            interruptRequestLow <= mpb_pkg::IRQ_LOW_RESET;
        else
            interruptRequestLow <= ~|(intStatus & intEnable); // [R11]
    end
endmodule // mpb_irq

/* mpb_host_model.sv */
// Host bus master model that drives the parallel port pins.
module mpb_host_model (
    // Clock
    input  wire logic       clk,
    // Pins driven by the host
    output logic            addrBit0OrMuxSelectLow,
    output logic            addressBitOne,
    output logic            addrBit2OrLatchStrobe,
    output logic            readOrDataStrobeLow,
    output logic            writeOrDirection,
    output logic            chipSelectLow,
    output logic            hwResetLow,
    output logic [7:0]      hostData,
    output logic            hostDataOe,
    // Resolved data bus
    input  wire logic [7:0] dataBus
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        {addrBit0OrMuxSelectLow, addressBitOne, addrBit2OrLatchStrobe} = 3'h0;
        {readOrDataStrobeLow, writeOrDirection, chipSelectLow, hwResetLow} = 4'hf;
        hostData = 8'h00;
        hostDataOe = 1'b0;
    end

    task automatic setReset(input logic level);
        @(posedge clk);
        hwResetLow <= level;
    endtask

    // One whole byte access; the strobe is held well past the synchroniser delay.
    task automatic access(input logic muxed, input logic moto, input logic wr, input logic sel,
                          input logic [2:0] addr, input logic [7:0] wdata,
                          output logic [7:0] rdata);
        @(posedge clk);
        chipSelectLow <= !sel;
        writeOrDirection <= moto ? !wr : 1'b1;
        if (muxed)
        begin
            addrBit0OrMuxSelectLow <= 1'b0;
            addressBitOne <= 1'b1;
            addrBit2OrLatchStrobe <= 1'b1;
            hostData <= {5'($urandom), addr};
            hostDataOe <= 1'b1;
            repeat (6) @(posedge clk);
            addrBit2OrLatchStrobe <= 1'b0;
            repeat (4) @(posedge clk);
        end
        else
        begin
            {addrBit2OrLatchStrobe, addressBitOne, addrBit0OrMuxSelectLow} <= addr;
        end
        hostData <= wdata;
        hostDataOe <= wr;
        @(posedge clk);
        if (moto || !wr)
            readOrDataStrobeLow <= 1'b0;
        else
            writeOrDirection <= 1'b0;
        repeat (10) @(posedge clk);
        rdata = dataBus;
        readOrDataStrobeLow <= 1'b1;
        writeOrDirection <= moto ? !wr : 1'b1;
        repeat (2) @(posedge clk);
        chipSelectLow <= 1'b1;
        hostDataOe <= 1'b0;
        writeOrDirection <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
endmodule // mpb_host_model

/* tb.sv */
// Self-checking testbench for the parallel host bus port.
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       busMuxed = 1'b0;
    logic       busMotorola = 1'b0;
    logic       pinAddr0, pinAddr1, pinAddr2, rdDsLow, wrDir, csLow, hwRstLow, hostDataOe;
    logic [7:0] hostData, dataBus, regWrData, regRdData;
    logic [2:0] lowOut, lowOe, regAddr;
    logic [4:0] upOut, upOe;
    logic       irqLow, engineReset, regWrite, regRead;
    logic [7:0] intStatus = 8'h00;
    logic [7:0] intEnable = 8'h00;
    logic [7:0] engMem [8] = '{default: 8'h00};
    int         expMem [8];
    int         mismatches = 0;
    int         checks = 0;
    int         wrPulses = 0;
    int         rdPulses = 0;

    always #5 clk = ~clk;

    // Device drive wins, then host drive, then the pull-ups.
    assign dataBus = ({upOe, lowOe} & {upOut, lowOut})
                   | (~{upOe, lowOe} & (hostDataOe ? hostData : 8'hff));
    assign regRdData = engMem[regAddr];

    always @(posedge clk)
    begin
        if (regWrite === 1'b1)
        begin
            engMem[regAddr] <= regWrData;
            wrPulses++;
        end
        if (regRead === 1'b1)
            rdPulses++;
    end

    mpb_host_model i_host (
        .clk(clk), .addrBit0OrMuxSelectLow(pinAddr0), .addressBitOne(pinAddr1),
        .addrBit2OrLatchStrobe(pinAddr2), .readOrDataStrobeLow(rdDsLow),
        .writeOrDirection(wrDir), .chipSelectLow(csLow), .hwResetLow(hwRstLow),
        .hostData(hostData), .hostDataOe(hostDataOe), .dataBus(dataBus)
    );

    mpb_port i_dut (
        .clk(clk), .rst(rst), .busMuxed(busMuxed), .busMotorola(busMotorola),
        .addrBit0OrMuxSelectLow(pinAddr0), .addressBitOne(pinAddr1),
        .addrBit2OrLatchStrobe(pinAddr2),
        .readOrDataStrobeLow(rdDsLow), .writeOrDirection(wrDir), .chipSelectLow(csLow),
        .hwResetLow(hwRstLow), .sharedLowAddrDataIn(dataBus[2:0]),
        .sharedLowAddrDataOut(lowOut), .sharedLowAddrDataOe(lowOe),
        .upperDataIn(dataBus[7:3]), .upperDataOut(upOut), .upperDataOe(upOe),
        .interruptRequestLow(irqLow), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .intStatus(intStatus), .intEnable(intEnable), .engineReset(engineReset)
    );

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        report_and_stop();
    end

    initial
    begin
        logic [7:0] q;
        logic [7:0] d;
        int         cnt;
        void'($urandom(32'h0da3c842));
        repeat (5) @(posedge clk);
        @(negedge clk);
        chk_bit(irqLow, 1'b1);
        chk_byte({upOe, lowOe}, 8'h00);
        @(posedge clk);
        rst <= 1'b0;
        $display("test reset done");
        for (int m = 0; m < 4; m++)
        begin
            @(posedge clk);
            busMuxed <= m[0];
            busMotorola <= m[1];
            for (int k = 0; k < 8; k++)
            begin
                d = 8'($urandom);
                cnt = wrPulses;
                i_host.access(m[0], m[1], 1'b1, 1'b1, 3'(k), d, q);
                expMem[k] = d;
                chk_byte({5'h00, regAddr}, 8'(k));
                chk_byte(regWrData, d);
                chk_byte(8'(wrPulses - cnt), 8'h01);
            end
            for (int k = 7; k >= 0; k--)
            begin
                cnt = rdPulses;
                i_host.access(m[0], m[1], 1'b0, 1'b1, 3'(k), 8'h00, q);
                chk_byte(q, 8'(expMem[k]));
                chk_byte({upOe, lowOe}, 8'h00);
                chk_byte(8'(rdPulses - cnt), 8'h01);
            end
            $display("test mode %0d done", m);
        end
        cnt = wrPulses;
        i_host.access(1'b1, 1'b1, 1'b1, 1'b0, 3'h5, ~8'(expMem[5]), q);
        chk_byte(8'(wrPulses - cnt), 8'h00);
        cnt = rdPulses;
        i_host.access(1'b1, 1'b1, 1'b0, 1'b0, 3'h5, 8'h00, q);
        chk_byte(q, 8'hff);
        chk_byte(8'(rdPulses - cnt), 8'h00);
        i_host.access(1'b1, 1'b1, 1'b0, 1'b1, 3'h5, 8'h00, q);
        chk_byte(q, 8'(expMem[5]));
        $display("test unselected done");
        for (int i = 0; i < 16; i++)
        begin
            @(posedge clk);
            intStatus <= (i == 0) ? 8'hff : 8'($urandom);
            intEnable <= (i == 0) ? 8'h00 : 8'($urandom);
            repeat (3) @(negedge clk);
            chk_bit(irqLow, ~|(intStatus & intEnable));
        end
        $display("test interrupt done");
        i_host.setReset(1'b0);
        repeat (8) @(negedge clk);
        chk_bit(engineReset, 1'b1);
        chk_byte({5'h00, regAddr}, 8'h00);
        i_host.setReset(1'b1);
        repeat (8) @(negedge clk);
        chk_bit(engineReset, 1'b0);
        i_host.access(1'b1, 1'b1, 1'b0, 1'b1, 3'h5, 8'h00, q);
        chk_byte(q, 8'(expMem[5]));
        $display("test hardware reset done");
        report_and_stop();
    end
endmodule // tb
